// >>> fps_host.sv
module fps_host (
  input  wire logic       clk_in,
  input  wire logic       resp_valid_in,
  input  wire logic [7:0] resp_data_in,
  output logic            resp_ready_out,
  input  wire logic       stall_in,
  input  wire logic       nv_wr_in,
  input  wire logic [2:0] nv_wdata_in,
  output logic [2:0]      nv_sec_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  logic       tog = 1'b0;
  initial resp_ready_out = 1'b1;
  initial nv_sec_out = 3'h0; // Shipped with no bans
  // Collect reply bytes; a stalling host takes only every other cycle
  always @(posedge clk_in)
  begin
    if (resp_valid_in && resp_ready_out)
      q.push_back(resp_data_in);
    tog <= ~tog;
    resp_ready_out <= !stall_in || tog;
  end
  // Cell survives resets, so bans outlive the session
  always @(posedge clk_in)
    if (nv_wr_in)
      nv_sec_out <= nv_wdata_in;
endmodule

// >>> fps_params.svh
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH

// Security flag bit positions and reset value
`define FPS_SEC_ERASE 0
`define FPS_SEC_WRITE 1
`define FPS_SEC_BOOT 2
`define FPS_SEC_RESET 3'h0

// Boot region, lowest cluster
`define FPS_BOOT_HI 20'h00FFF

// Response codes
`define FPS_ACK 8'h06
`define FPS_NAK 8'h15

// Signature reply: code byte plus 19 data bytes
`define FPS_SIG_BYTES 19
`define FPS_SIG_LAST 5'h13
`define FPS_SIG_W 152

// Response FIFO shape
`define FPS_FIFO_W 8
`define FPS_FIFO_D 4

`endif

// >>> fps_pkg.sv
package fps_pkg;

  // Command codes seen on cmd_op_in; codes above these are illegal
  typedef enum logic [2:0] {
    FPS_OP_ERASE,
    FPS_OP_WRITE,
    FPS_OP_SIG,
    FPS_OP_SEC_SET,
    FPS_OP_SEC_REL
  } fps_op_t;

  typedef enum logic {
    FPS_ST_IDLE,
    FPS_ST_SEND
  } fps_state_t;

  // Whole state of the interpreter
  typedef struct packed {
    fps_state_t  st;
    logic [4:0]  idx;
    logic        sig;
    logic [7:0]  code;
    logic        loaded;
    logic        set_seen;
    logic [2:0]  act;
    logic        cmd_ready;
    logic        erase;
    logic        write;
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic        nv_wr;
    logic [2:0]  nv_wdata;
  } fps_state_s_t;

endpackage

// >>> fps_top.sv
`include "fps_params.svh"

// Shift-register FIFO: head always sits in slot 0, so every output is a flop
module fps_fifo #(
  parameter int WIDTH = `FPS_FIFO_W,
  parameter int DEPTH = `FPS_FIFO_D
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);

  // Slot contents, occupancy and registered ready
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [DEPTH-1:0]            vld;
    logic                        in_ready;
  } fps_fifo_s_t;

  // Current state and its next value
  fps_fifo_s_t r;
  fps_fifo_s_t next_r;

  // Pop shifts down first, then push fills the lowest empty slot
  always_comb
  begin
    logic pop;
    logic push;
    int   pos;
    pop    = r.vld[0] & out_ready_in;
    push   = in_valid_in & r.in_ready;
    pos    = DEPTH - 1;
    next_r = r;
    if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        next_r.mem[i] = r.mem[i+1];
        next_r.vld[i] = r.vld[i+1];
      end
      next_r.mem[DEPTH-1] = '0;
      next_r.vld[DEPTH-1] = 1'b0;
    end
    // Lowest empty slot once the pop is done
    for (int i = DEPTH - 1; i >= 0; i--)
    begin
      if (!next_r.vld[i])
      begin
        pos = i;
      end
    end
    // Ready was low when full, so a push always finds room
    if (push)
    begin
      next_r.mem[pos] = in_data_in;
      next_r.vld[pos] = 1'b1;
    end
    // Ready drops only when the last slot is really taken
    next_r.in_ready = ~next_r.vld[DEPTH-1];
  end

  // Sync reset empties every slot
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      r.mem      <= '0;
      r.vld      <= '0;
      r.in_ready <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Head slot drives the outputs straight from flops
  assign in_ready_out  = r.in_ready;
  assign out_valid_out = r.vld[0];
  assign out_data_out  = r.mem[0];

endmodule

module fps_top #(
  parameter logic [23:0] DEV_CODE  = 24'hA55A01, // Arbitrary identity value
  parameter logic [79:0] DEV_NAME  = 80'h46505344455620202020,
  parameter logic [19:0] LAST_ADDR = 20'h01FFF,
  parameter logic [23:0] FW_VER    = 24'h010203
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        cmd_valid_in,
  output logic             cmd_ready_out,
  input  wire logic [2:0]  cmd_op_in,
  input  wire logic [19:0] cmd_addr_in,
  input  wire logic [7:0]  cmd_data_in,
  input  wire logic [2:0]  cmd_sec_in,
  input  wire logic        self_prog_in,
  input  wire logic        session_start_in,
  input  wire logic [2:0]  nv_sec_in,
  input  wire logic        blank_in,
  output logic             nv_wr_out,
  output logic [2:0]       nv_wdata_out,
  output logic             flash_erase_out,
  output logic             flash_write_out,
  output logic [19:0]      flash_addr_out,
  output logic [7:0]       flash_wdata_out,
  output logic [2:0]       sec_active_out,
  output logic             sec_loaded_out,
  output logic             resp_valid_out,
  output logic [7:0]       resp_data_out,
  input  wire logic        resp_ready_in
);

  // Reply image in send order; address bytes go out low first
  localparam logic [`FPS_SIG_W-1:0] SIG_VEC = {
    DEV_CODE,
    DEV_NAME,
    LAST_ADDR[7:0],
    LAST_ADDR[15:8],
    4'h0, LAST_ADDR[19:16],
    FW_VER
  };

  // Interpreter state, one packed word
  fps_pkg::fps_state_s_t r;
  fps_pkg::fps_state_s_t next_r;

  // Interpreter side of the reply FIFO
  logic       push_valid;
  logic [7:0] push_data;
  logic       push_ready;

  // Byte k (1..19) of the signature image
  function automatic logic [7:0] sig_byte(input logic [4:0] k);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 1; i <= `FPS_SIG_BYTES; i++)
    begin
      if (k == 5'(i))
      begin
        b = SIG_VEC[(`FPS_SIG_BYTES - i) * 8 +: 8];
      end
    end
    return b;
  endfunction

  // Lowest cluster address check, used by erase and write
  function automatic logic in_boot(input logic [19:0] a);
    return a <= `FPS_BOOT_HI;
  endfunction

  // Shared refusal test: own ban for outside callers, boot ban for all
  function automatic logic refused(input logic        ext,
                                   input logic        ban,
                                   input logic        boot_ban,
                                   input logic [19:0] a);
    logic hit;
    hit = ext & ban;
    hit = hit | (boot_ban & in_boot(a));
    return hit;
  endfunction

  // First byte of every reply is the verdict, then signature data
  assign push_valid = (r.st == fps_pkg::FPS_ST_SEND);
  assign push_data  = (r.idx == 5'h00) ? r.code : sig_byte(r.idx);

  // Interpreter: one command at a time, verdict decided on acceptance
  always_comb
  begin
    logic ext;
    logic ok;
    ext    = ~self_prog_in;
    ok     = 1'b0;
    next_r = r;
    // Flash and cell strobes last one cycle only
    next_r.erase = 1'b0;
    next_r.write = 1'b0;
    next_r.nv_wr = 1'b0;
    // Stored flags become the gate only at mode entry
    if (session_start_in)
    begin
      next_r.act    = nv_sec_in;
      next_r.loaded = 1'b1;
    end
    // Command decode and reply sequencing
    unique case (r.st)
      fps_pkg::FPS_ST_IDLE:
      begin
        next_r.cmd_ready = 1'b1;
        if (cmd_valid_in && r.cmd_ready)
        begin
          // Ready drops at once so no second command slips in
          next_r.cmd_ready = 1'b0;
          next_r.st        = fps_pkg::FPS_ST_SEND;
          next_r.idx       = 5'h00;
          next_r.sig       = 1'b0;
          next_r.addr      = cmd_addr_in;
          next_r.wdata     = cmd_data_in;
          case (cmd_op_in)
            fps_pkg::FPS_OP_ERASE:
            begin
              // External erase ban; self programming ignores it
              ok = r.loaded
                 & ~refused(ext, r.act[`FPS_SEC_ERASE],
                            r.act[`FPS_SEC_BOOT], cmd_addr_in);
              next_r.erase = ok;
            end
            fps_pkg::FPS_OP_WRITE:
            begin
              // Write ban leaves erase alone
              ok = r.loaded
                 & ~refused(ext, r.act[`FPS_SEC_WRITE],
                            r.act[`FPS_SEC_BOOT], cmd_addr_in);
              next_r.write = ok;
            end
            fps_pkg::FPS_OP_SIG:
            begin
              ok         = 1'b1;
              next_r.sig = 1'b1;
            end
            fps_pkg::FPS_OP_SEC_SET:
            begin
              // Bits only ever add; any mix may be set
              ok              = ext & r.loaded;
              next_r.nv_wr    = ok;
              next_r.nv_wdata = nv_sec_in | cmd_sec_in;
              next_r.set_seen = r.set_seen | ok;
            end
            fps_pkg::FPS_OP_SEC_REL:
            begin
              // Only the write ban can come off
              ok = ext & r.loaded
                 & ~r.set_seen
                 & r.act[`FPS_SEC_ERASE] & r.act[`FPS_SEC_BOOT]
                 & blank_in;
              next_r.nv_wr    = ok;
              next_r.nv_wdata = nv_sec_in & ~(3'h1 << `FPS_SEC_WRITE);
            end
            default:
            begin
              ok = 1'b0;
            end
          endcase
          // Verdict byte leads every reply
          next_r.code = ok ? `FPS_ACK : `FPS_NAK;
        end
      end
      fps_pkg::FPS_ST_SEND:
      begin
        // Stalls here while the reply FIFO is full
        if (push_ready)
        begin
          // Verdict alone, or verdict and 19 signature bytes
          if ((!r.sig && r.idx == 5'h00) || (r.sig && r.idx == `FPS_SIG_LAST))
          begin
            next_r.st        = fps_pkg::FPS_ST_IDLE;
            next_r.cmd_ready = 1'b1;
          end
          else
          begin
            next_r.idx = r.idx + 5'h01;
          end
        end
      end
    endcase
  end

  // Reset clears the session: bans stay unloaded until mode entry
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      r.st        <= fps_pkg::FPS_ST_IDLE;
      r.idx       <= 5'h00;
      r.sig       <= 1'b0;
      r.code      <= 8'h00;
      r.loaded    <= 1'b0;
      r.set_seen  <= 1'b0;
      r.act       <= `FPS_SEC_RESET;
      r.cmd_ready <= 1'b0;
      r.erase     <= 1'b0;
      r.write     <= 1'b0;
      r.addr      <= 20'h00000;
      r.wdata     <= 8'h00;
      r.nv_wr     <= 1'b0;
      r.nv_wdata  <= `FPS_SEC_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Reply path; host back-pressure stalls the interpreter
  fps_fifo #(
    .WIDTH (`FPS_FIFO_W),
    .DEPTH (`FPS_FIFO_D)
  ) u_resp_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (push_valid),
    .in_data_in    (push_data),
    .in_ready_out  (push_ready),
    .out_valid_out (resp_valid_out),
    .out_data_out  (resp_data_out),
    .out_ready_in  (resp_ready_in)
  );

  // Outputs straight from state flops
  assign cmd_ready_out   = r.cmd_ready;
  assign nv_wr_out       = r.nv_wr;
  assign nv_wdata_out    = r.nv_wdata;
  assign flash_erase_out = r.erase;
  assign flash_write_out = r.write;
  assign flash_addr_out  = r.addr;
  assign flash_wdata_out = r.wdata;
  assign sec_active_out  = r.act;
  assign sec_loaded_out  = r.loaded;

endmodule

// >>> fps_top_assertions.sv
module fps_checker (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        cmd_valid_in,
  input wire logic        cmd_ready_out,
  input wire logic [2:0]  cmd_op_in,
  input wire logic [19:0] cmd_addr_in,
  input wire logic [2:0]  cmd_sec_in,
  input wire logic        self_prog_in,
  input wire logic        session_start_in,
  input wire logic [2:0]  nv_sec_in,
  input wire logic        blank_in,
  input wire logic        nv_wr_out,
  input wire logic [2:0]  nv_wdata_out,
  input wire logic        flash_erase_out,
  input wire logic        flash_write_out,
  input wire logic [19:0] flash_addr_out,
  input wire logic [2:0]  sec_active_out,
  input wire logic        sec_loaded_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Take edge and boot-region hit
  logic tk;
  logic boot;
  assign tk   = cmd_valid_in && cmd_ready_out;
  assign boot = sec_active_out[2] && (cmd_addr_in <= 20'h00FFF);
  property p_ext_erase;
    tk && cmd_op_in == 3'h0 && !self_prog_in && sec_active_out[0] |=> !flash_erase_out;
  endproperty
  a_ext_erase: assert property (p_ext_erase) else $error("banned erase ran");
  property p_ext_write;
    tk && cmd_op_in == 3'h1 && !self_prog_in && sec_active_out[1] |=> !flash_write_out;
  endproperty
  a_ext_write: assert property (p_ext_write) else $error("banned write ran");
  property p_boot;
    tk && cmd_op_in <= 3'h1 && boot |=> !flash_erase_out && !flash_write_out;
  endproperty
  a_boot: assert property (p_boot) else $error("boot region touched");
  // Self erase outside boot goes through once the bans are loaded, whatever the erase ban
  property p_self_erase;
    tk && cmd_op_in == 3'h0 && self_prog_in && sec_loaded_out && !boot
    |=> flash_erase_out && flash_addr_out == $past(cmd_addr_in);
  endproperty
  a_self_erase: assert property (p_self_erase) else $error("self erase lost");
  property p_rel;
    tk && cmd_op_in == 3'h4 && !(blank_in && sec_active_out[0] && sec_active_out[2])
    |=> !nv_wr_out;
  endproperty
  a_rel: assert property (p_rel) else $error("release not allowed");
  property p_set;
    tk && cmd_op_in == 3'h3 && !self_prog_in && sec_loaded_out
    |=> nv_wr_out && nv_wdata_out == ($past(nv_sec_in) | $past(cmd_sec_in));
  endproperty
  a_set: assert property (p_set) else $error("set not stored");
  property p_hold;
    $changed(sec_active_out) |-> $past(session_start_in);
  endproperty
  a_hold: assert property (p_hold) else $error("gate moved mid session");
  property p_load;
    session_start_in |=> sec_active_out == $past(nv_sec_in) && sec_loaded_out;
  endproperty
  a_load: assert property (p_load) else $error("gate not loaded");
  c_sig: cover property (tk && cmd_op_in == 3'h2);
  c_nv: cover property (nv_wr_out);
  c_boot: cover property (tk && boot);
endmodule

bind fps_top fps_checker u_chk (
  .clk_in           (clk_in),
  .rst_n_in         (rst_n_in),
  .cmd_valid_in     (cmd_valid_in),
  .cmd_ready_out    (cmd_ready_out),
  .cmd_op_in        (cmd_op_in),
  .cmd_addr_in      (cmd_addr_in),
  .cmd_sec_in       (cmd_sec_in),
  .self_prog_in     (self_prog_in),
  .session_start_in (session_start_in),
  .nv_sec_in        (nv_sec_in),
  .blank_in         (blank_in),
  .nv_wr_out        (nv_wr_out),
  .nv_wdata_out     (nv_wdata_out),
  .flash_erase_out  (flash_erase_out),
  .flash_write_out  (flash_write_out),
  .flash_addr_out   (flash_addr_out),
  .sec_active_out   (sec_active_out),
  .sec_loaded_out   (sec_loaded_out)
);

// >>> testbench.sv
`include "fps_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, rst_n_in = 1'b0, cmd_valid_in = 1'b0, self_prog_in = 1'b0;
  logic session_start_in = 1'b0, blank_in = 1'b0, stall = 1'b0;
  logic [2:0] cmd_op_in = 3'h0, cmd_sec_in = 3'h0, nv_sec_in, nv_wdata_out, sec_active_out;
  logic [19:0] cmd_addr_in = 20'h00000, flash_addr_out;
  logic [7:0] cmd_data_in = 8'h00, flash_wdata_out, resp_data_out;
  logic cmd_ready_out, nv_wr_out, flash_erase_out, flash_write_out, sec_loaded_out;
  logic resp_valid_out, resp_ready_in;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_pulse = 0;
  always #2.5 clk_in = ~clk_in;
  fps_top DUT (
    .clk_in           (clk_in),
    .rst_n_in         (rst_n_in),
    .cmd_valid_in     (cmd_valid_in),
    .cmd_ready_out    (cmd_ready_out),
    .cmd_op_in        (cmd_op_in),
    .cmd_addr_in      (cmd_addr_in),
    .cmd_data_in      (cmd_data_in),
    .cmd_sec_in       (cmd_sec_in),
    .self_prog_in     (self_prog_in),
    .session_start_in (session_start_in),
    .nv_sec_in        (nv_sec_in),
    .blank_in         (blank_in),
    .nv_wr_out        (nv_wr_out),
    .nv_wdata_out     (nv_wdata_out),
    .flash_erase_out  (flash_erase_out),
    .flash_write_out  (flash_write_out),
    .flash_addr_out   (flash_addr_out),
    .flash_wdata_out  (flash_wdata_out),
    .sec_active_out   (sec_active_out),
    .sec_loaded_out   (sec_loaded_out),
    .resp_valid_out   (resp_valid_out),
    .resp_data_out    (resp_data_out),
    .resp_ready_in    (resp_ready_in)
  );
  fps_host u_host (.clk_in(clk_in), .resp_valid_in(resp_valid_out),
    .resp_data_in(resp_data_out), .resp_ready_out(resp_ready_in), .stall_in(stall),
    .nv_wr_in(nv_wr_out), .nv_wdata_in(nv_wdata_out), .nv_sec_out(nv_sec_in));
  // Flash pulses counted so refusals can be seen to leave flash alone
  always @(posedge clk_in)
    n_pulse <= n_pulse + int'(flash_erase_out) + int'(flash_write_out);
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Next reply byte, bounded wait so a silent design cannot hang us
  task automatic next_byte(input logic [7:0] exp);
    int k;
    k = 0;
    while (u_host.q.size() == 0 && k < 100)
    begin
      @(negedge clk_in);
      k++;
    end
    check((k < 100) ? u_host.q.pop_front() : 8'hXX, exp);
  endtask
  // One command, valid for one cycle once ready is high; checks verdict and flash pulse count
  task automatic cmd(input logic [2:0] op, input logic [19:0] a, input logic s,
                     input logic [7:0] exp);
    int k;
    int p;
    k = 0;
    while (cmd_ready_out !== 1'b1 && k < 100)
    begin
      @(negedge clk_in);
      k++;
    end
    p = n_pulse;
    cmd_op_in = op;
    cmd_addr_in = a;
    cmd_data_in = a[7:0];
    self_prog_in = s;
    cmd_valid_in = 1'b1;
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    // Operands latched at the take edge feed the flash strobes
    if (op <= 3'h1)
    begin
      check(flash_wdata_out, a[7:0]);
      check(8'(flash_addr_out === a), 8'h01);
    end
    next_byte(exp);
    check(8'(n_pulse - p), (exp == `FPS_ACK && op <= 3'h1) ? 8'h01 : 8'h00);
  endtask
  task automatic session();
    session_start_in = 1'b1;
    @(negedge clk_in);
    session_start_in = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic t_unloaded();
    cmd(3'h0, 20'h01000, 1'b0, `FPS_NAK);
  endtask
  task automatic t_sig();
    logic [151:0] sig;
    sig = {24'hA55A01, 80'h46505344455620202020, 24'hFF1F00, 24'h010203};
    stall = 1'b1;
    cmd(3'h2, 20'h00000, 1'b0, `FPS_ACK);
    for (int i = 0; i < 19; i++)
      next_byte(sig[151 - 8 * i -: 8]);
    stall = 1'b0;
  endtask
  task automatic t_ship();
    session();
    cmd(3'h0, 20'h00000, 1'b0, `FPS_ACK);
    cmd(3'h1, 20'h00010, 1'b0, `FPS_ACK);
  endtask
  // Undefined command codes must be refused, no strobe
  task automatic t_illegal();
    cmd(3'h5, 20'h01000, 1'b0, `FPS_NAK);
    cmd(3'h7, 20'h01000, 1'b0, `FPS_NAK);
  endtask
  task automatic t_set();
    cmd_sec_in = 3'h5;
    cmd(3'h3, 20'h00000, 1'b1, `FPS_NAK);
    cmd(3'h3, 20'h00000, 1'b0, `FPS_ACK);
    cmd_sec_in = 3'h2;
    cmd(3'h3, 20'h00000, 1'b0, `FPS_ACK);
    check({5'h00, nv_sec_in}, 8'h07);
    cmd(3'h0, 20'h01000, 1'b0, `FPS_ACK);
    blank_in = 1'b1;
    cmd(3'h4, 20'h00000, 1'b0, `FPS_NAK);
  endtask
  task automatic t_ban();
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    @(negedge clk_in);
    session();
    check({5'h00, sec_active_out}, 8'h07);
    cmd(3'h0, 20'h01000, 1'b0, `FPS_NAK);
    cmd(3'h0, 20'h01000, 1'b1, `FPS_ACK);
    cmd(3'h1, 20'h01000, 1'b0, `FPS_NAK);
    cmd(3'h1, 20'h01000, 1'b1, `FPS_ACK);
    cmd(3'h0, 20'h00FFF, 1'b1, `FPS_NAK);
    cmd(3'h1, 20'h00000, 1'b1, `FPS_NAK);
    blank_in = 1'b0;
    cmd(3'h4, 20'h00000, 1'b0, `FPS_NAK);
    blank_in = 1'b1;
    cmd(3'h4, 20'h00000, 1'b0, `FPS_ACK);
    check({5'h00, nv_sec_in}, 8'h05);
    session();
    cmd(3'h1, 20'h01100, 1'b0, `FPS_ACK);
    cmd(3'h0, 20'h01000, 1'b0, `FPS_NAK);
    // Erase and boot bans in force, flash blank: only the fresh set blocks release
    cmd_sec_in = 3'h0;
    cmd(3'h3, 20'h00000, 1'b0, `FPS_ACK);
    cmd(3'h4, 20'h00000, 1'b0, `FPS_NAK);
    check({5'h00, nv_sec_in}, 8'h05);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog: the whole run needs a few thousand cycles at most
  initial
  begin
    #100000;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    repeat (4) @(negedge clk_in);
    rst_n_in = 1'b1;
    @(negedge clk_in);
    t_unloaded();
    t_sig();
    t_ship();
    t_illegal();
    t_set();
    t_ban();
    stop_test();
  end
endmodule
